// ---- hdl/ncs_kernel_tracker.sv ----
`timescale 1ns/1ps
// Counts kernel operations that are started but not yet written back.
module ncs_kernel_tracker #(
    parameter int unsigned CNT_W = 4
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Events.
    input  wire logic             start,
    input  wire logic             done,
    // State.
    output logic [CNT_W-1:0]      count,
    output logic                  full
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    wire              inc = start & ~full;
    wire              dec = done & (count_q != '0);

    assign full  = (count_q == {CNT_W{1'b1}});
    assign count = count_q;

    always_comb begin
        count_d = count_q;
        if (inc & ~dec) begin
            count_d = count_q + 1'b1;
        end else if (dec & ~inc) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// ---- hdl/ncs_pkg.sv ----
package ncs_pkg;

    // Short-form command word layout.
    localparam int unsigned SHORT_TAG_HI   = 15;
    localparam int unsigned SHORT_TAG_LO   = 10;
    localparam int unsigned OPCODE_HI      = 9;
    localparam int unsigned OPCODE_LO      = 0;
    localparam logic [5:0]  SHORT_TAG      = 6'h00;

    // Opcodes.
    localparam logic [9:0]  OP_HALT        = 10'h000;
    localparam logic [9:0]  OP_HOST_IRQ    = 10'h001;
    localparam logic [9:0]  OP_CONV        = 10'h002;
    localparam logic [9:0]  OP_PER_CHAN    = 10'h003;
    localparam logic [9:0]  OP_POOL        = 10'h005;
    localparam logic [9:0]  OP_POINTWISE   = 10'h006;
    localparam logic [9:0]  OP_XFER_QUEUE  = 10'h010;
    localparam logic [9:0]  OP_XFER_WAIT   = 10'h011;
    localparam logic [9:0]  OP_COMPUTE_WAIT = 10'h012;
    localparam logic [9:0]  OP_DEP_DIST    = 10'h12f;
    localparam logic [9:0]  OP_STATE_BASE  = 10'h100;
    localparam logic [9:0]  OP_STATE_LAST  = 10'h1ff;

    // Parameter fields.
    localparam int unsigned CHAN_LSB       = 4;
    localparam logic [3:0]  CHAN_ZERO      = 4'h0;
    localparam int unsigned STATUS_SHIFT   = 16;
    localparam logic [15:0] POOL_MODE_MAX  = 16'h0001;
    localparam logic [15:0] PW_MODE_MAX    = 16'h0006;
    localparam logic [15:0] CONV_PARAM     = 16'h0000;
    localparam logic [1:0]  KWAIT_MAX      = 2'h3;

    // Kernel kinds driven to the compute engine.
    localparam logic [1:0]  KIND_CONV      = 2'h0;
    localparam logic [1:0]  KIND_PER_CHAN  = 2'h1;
    localparam logic [1:0]  KIND_POOL      = 2'h2;
    localparam logic [1:0]  KIND_POINTWISE = 2'h3;

    // Transfer channel capacity.
    localparam logic [1:0]  XFER_SLOTS     = 2'h2;

    // Register byte offsets.
    localparam logic [7:0]  REG_CONTROL    = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_COUNTS     = 8'h08;
    localparam logic [7:0]  REG_STATE_IDX  = 8'h0c;
    localparam logic [7:0]  REG_STATE_DATA = 8'h10;

    // Control register bits.
    localparam int unsigned CTL_RESUME     = 0;
    localparam int unsigned CTL_IRQ_CLR    = 1;

    // Status register bits.
    localparam int unsigned ST_STOPPED     = 0;
    localparam int unsigned ST_IRQ         = 1;
    localparam int unsigned ST_BUSY        = 2;

    // Count register field positions.
    localparam int unsigned CNT_KERN_LSB   = 0;
    localparam int unsigned CNT_XFER_LSB   = 8;
    localparam int unsigned CNT_DEP_LSB    = 16;

    // Reset values.
    localparam logic [1:0]  DEP_DIST_RST   = 2'h0;
    localparam logic [15:0] STATUS_HI_RST  = 16'h0000;

    typedef enum logic {
        NCS_FETCH,
        NCS_EXEC
    } ncs_state_e;

endpackage

// ---- hdl/ncs_sequencer.sv ----
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ncs_sequencer #(
    parameter int unsigned KCNT_W  = 4,
    parameter int unsigned STATE_N = 256
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Command stream.
    input  wire logic              cmd_valid,
    input  wire logic [15:0]       short_command_word,
    input  wire logic [15:0]       cmd_param,
    output logic                   cmd_ready,
    // Kernel engine.
    output logic                   kernel_start,
    output logic [1:0]             kernel_kind,
    output logic [15:0]            kernel_mode,
    input  wire logic              kernel_done,
    // Transfer queue.
    output logic                   xfer_valid,
    output logic [3:0]             xfer_channel,
    input  wire logic              xfer_ready,
    input  wire logic              xfer_done,
    // Host side.
    output logic                   host_irq,
    output logic                   stopped
);

    ncs_pkg::ncs_state_e state_q;
    ncs_pkg::ncs_state_e state_d;

    // The command slot holds one word and its parameter.
    logic [15:0]       code_q;
    logic [15:0]       param_q;
    logic              cmd_ready_q;

    // Registered kernel engine outputs.
    logic              kernel_start_q;
    logic [1:0]        kernel_kind_q;
    logic [15:0]       kernel_mode_q;

    // Registered transfer outputs.
    logic              xfer_valid_q;
    logic [3:0]        xfer_channel_q;

    // Host status and the parameter of the last halt or host interrupt.
    logic              host_irq_q;
    logic              stopped_q;
    logic [15:0]       status_hi_q;

    // Counters and state kept for later operations.
    logic [1:0]        dep_dist_q;
    logic [1:0]        xfer_active_q;
    logic [7:0]        state_idx_q;
    logic [15:0]       state_mem [STATE_N];

    // Registered register bus answer.
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;

    logic [KCNT_W-1:0] kern_cnt;
    logic              kern_full;

    function automatic logic kern_le(input logic [KCNT_W-1:0] cnt, input logic [1:0] lim);
        kern_le = (cnt <= KCNT_W'(lim));
    endfunction

    // Command decode.
    wire [9:0]  opcode     = code_q[ncs_pkg::OPCODE_HI:ncs_pkg::OPCODE_LO];
    wire        is_short   = (code_q[ncs_pkg::SHORT_TAG_HI:ncs_pkg::SHORT_TAG_LO] == ncs_pkg::SHORT_TAG);
    wire [3:0]  param_chan = param_q[ncs_pkg::CHAN_LSB +: 4];
    wire [1:0]  param_k    = param_q[1:0];
    wire        chan_ok    = (param_chan == ncs_pkg::CHAN_ZERO);
    wire        exec       = (state_q == ncs_pkg::NCS_EXEC);

    // Halt and host interrupt.
    wire        op_halt    = exec & is_short & (opcode == ncs_pkg::OP_HALT);
    wire        op_irq     = exec & is_short & (opcode == ncs_pkg::OP_HOST_IRQ);

    // Kernel starts; a parameter out of range makes the command retire idle.
    wire        op_conv    = exec & is_short & (opcode == ncs_pkg::OP_CONV)
                             & (param_q == ncs_pkg::CONV_PARAM);
    wire        op_perch   = exec & is_short & (opcode == ncs_pkg::OP_PER_CHAN)
                             & (param_q == ncs_pkg::CONV_PARAM);
    wire        op_pool    = exec & is_short & (opcode == ncs_pkg::OP_POOL)
                             & (param_q <= ncs_pkg::POOL_MODE_MAX);
    wire        op_pw      = exec & is_short & (opcode == ncs_pkg::OP_POINTWISE)
                             & (param_q <= ncs_pkg::PW_MODE_MAX);

    // Transfer commands act on channel zero only.
    wire        op_xq      = exec & is_short & (opcode == ncs_pkg::OP_XFER_QUEUE) & chan_ok;
    wire        op_xw      = exec & is_short & (opcode == ncs_pkg::OP_XFER_WAIT) & chan_ok;

    // Waits, the dependency distance and stored state.
    wire        op_kw      = exec & is_short & (opcode == ncs_pkg::OP_COMPUTE_WAIT);
    wire        op_dep     = exec & is_short & (opcode == ncs_pkg::OP_DEP_DIST);
    wire        op_state   = exec & is_short & (opcode >= ncs_pkg::OP_STATE_BASE)
                             & (opcode <= ncs_pkg::OP_STATE_LAST) & ~op_dep;
    wire        op_kernel  = op_conv | op_perch | op_pool | op_pw;

    // Completion conditions for the command held in the execute slot.
    wire        kern_idle  = (kern_cnt == '0);
    // A kernel overlaps earlier ones only up to the dependency distance.
    wire        kern_go    = op_kernel & ~kern_full & kern_le(kern_cnt, dep_dist_q);
    // Halt and host interrupt wait until every started kernel is written back.
    wire        halt_go    = op_halt & kern_idle;
    wire        irq_go     = op_irq & kern_idle;
    // A descriptor queues only into a free slot of the channel.
    wire        xq_go      = op_xq & xfer_ready & (xfer_active_q < ncs_pkg::XFER_SLOTS);
    wire        xw_go      = op_xw & (xfer_active_q <= param_k);
    wire        kw_go      = op_kw & (param_q[1:0] <= ncs_pkg::KWAIT_MAX)
                             & kern_le(kern_cnt, param_q[1:0]);
    wire        waiting    = op_kernel | op_halt | op_irq | op_xq | op_xw | op_kw;
    wire        go_any     = kern_go | halt_go | irq_go | xq_go | xw_go | kw_go;
    // Anything else in the slot (state setting, dependency, unknown) retires at once.
    wire        retire     = exec & (go_any | ~waiting);

    // A word is taken at an edge where valid and ready are both high.
    wire        take_cmd   = cmd_valid & cmd_ready_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ncs_pkg::NCS_FETCH: begin
                if (take_cmd) begin
                    state_d = ncs_pkg::NCS_EXEC;
                end
            end
            ncs_pkg::NCS_EXEC: begin
                if (retire) begin
                    state_d = ncs_pkg::NCS_FETCH;
                end
            end
            default: begin
                state_d = ncs_pkg::NCS_FETCH;
            end
        endcase
    end

    // Outstanding kernel operations, counted from start to write-back.
    ncs_kernel_tracker #(
        .CNT_W (KCNT_W)
    ) u_kern (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (kern_go),
        .done    (kernel_done),
        .count   (kern_cnt),
        .full    (kern_full)
    );

    // APB decode.
    wire        apb_acc    = psel & penable & pready_q;
    wire        apb_wr     = apb_acc & pwrite;
    wire        addr_ok    = (paddr == ncs_pkg::REG_CONTROL) | (paddr == ncs_pkg::REG_STATUS)
                             | (paddr == ncs_pkg::REG_COUNTS) | (paddr == ncs_pkg::REG_STATE_IDX)
                             | (paddr == ncs_pkg::REG_STATE_DATA);
    wire        ctl_wr     = apb_wr & (paddr == ncs_pkg::REG_CONTROL);
    wire        idx_wr     = apb_wr & (paddr == ncs_pkg::REG_STATE_IDX);
    wire        resume     = ctl_wr & pwdata[ncs_pkg::CTL_RESUME];
    wire        irq_clr    = ctl_wr & pwdata[ncs_pkg::CTL_IRQ_CLR];

    // Read views of the status and count registers.
    wire [31:0] status_rd  = {status_hi_q, 13'h0000, exec, host_irq_q, stopped_q};
    wire [31:0] counts_rd  = {14'h0000, dep_dist_q, 6'h00, xfer_active_q,
                              {(8 - KCNT_W){1'b0}}, kern_cnt};
    wire [31:0] rd_mux     = (paddr == ncs_pkg::REG_STATUS)     ? status_rd :
                             (paddr == ncs_pkg::REG_COUNTS)     ? counts_rd :
                             (paddr == ncs_pkg::REG_STATE_IDX)  ? {24'h000000, state_idx_q} :
                             (paddr == ncs_pkg::REG_STATE_DATA) ? {16'h0000, state_mem[state_idx_q]} :
                             32'h00000000;

    // Transfer descriptor bookkeeping: a slot frees only on write-back completion.
    wire        xfer_inc   = xq_go;
    wire        xfer_dec   = xfer_done & (xfer_active_q != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ncs_pkg::NCS_FETCH;
        end else begin
            state_q <= state_d;
        end
    end

    // Command intake; nothing is accepted while halted or while a command executes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ready_q <= 1'b0;
            code_q      <= 16'h0000;
            param_q     <= 16'h0000;
        end else begin
            cmd_ready_q <= (state_d == ncs_pkg::NCS_FETCH) & ~take_cmd & ~stopped_q & ~halt_go;
            if (take_cmd) begin
                code_q  <= short_command_word;
                param_q <= cmd_param;
            end
        end
    end

    // Kernel start; the engine latches kind and mode with the pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kernel_start_q <= 1'b0;
            kernel_kind_q  <= ncs_pkg::KIND_CONV;
            kernel_mode_q  <= 16'h0000;
        end else begin
            kernel_start_q <= kern_go;
            if (kern_go) begin
                kernel_kind_q <= op_conv  ? ncs_pkg::KIND_CONV :
                                 op_perch ? ncs_pkg::KIND_PER_CHAN :
                                 op_pool  ? ncs_pkg::KIND_POOL : ncs_pkg::KIND_POINTWISE;
                kernel_mode_q <= param_q;
            end
        end
    end

    // Transfer descriptor queueing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_valid_q   <= 1'b0;
            xfer_channel_q <= ncs_pkg::CHAN_ZERO;
            xfer_active_q  <= 2'h0;
        end else begin
            xfer_valid_q <= xq_go;
            if (xq_go) begin
                xfer_channel_q <= param_chan;
            end
            if (xfer_inc & ~xfer_dec) begin
                xfer_active_q <= xfer_active_q + 2'h1;
            end else if (xfer_dec & ~xfer_inc) begin
                xfer_active_q <= xfer_active_q - 2'h1;
            end
        end
    end

    // Halt and host interrupt; a raise wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_irq_q  <= 1'b0;
            stopped_q   <= 1'b0;
            status_hi_q <= ncs_pkg::STATUS_HI_RST;
        end else begin
            if (halt_go | irq_go) begin
                host_irq_q  <= 1'b1;
                status_hi_q <= param_q;
            end else if (irq_clr) begin
                host_irq_q  <= 1'b0;
            end
            if (halt_go) begin
                stopped_q <= 1'b1;
            end else if (resume) begin
                stopped_q <= 1'b0;
            end
        end
    end

    // Stored state used by later operations.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dep_dist_q  <= ncs_pkg::DEP_DIST_RST;
            state_idx_q <= 8'h00;
        end else begin
            if (op_dep) begin
                dep_dist_q <= param_q[1:0];
            end
            if (idx_wr) begin
                state_idx_q <= pwdata[7:0];
            end
        end
    end

    // State memory holds no reset; each entry is written before software reads it.
    always_ff @(posedge pclk) begin
        if (op_state) begin
            state_mem[opcode[7:0]] <= param_q;
        end
    end

    // APB answer: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~addr_ok;
            if (psel & penable & ~pready_q & ~pwrite) begin
                prdata_q <= rd_mux;
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;

    // Command, engine and host outputs.
    assign cmd_ready    = cmd_ready_q;
    assign kernel_start = kernel_start_q;
    assign kernel_kind  = kernel_kind_q;
    assign kernel_mode  = kernel_mode_q;
    assign xfer_valid   = xfer_valid_q;
    assign xfer_channel = xfer_channel_q;
    assign host_irq     = host_irq_q;
    assign stopped      = stopped_q;

endmodule

// ---- verif/ncs_engine_model.sv ----
`timescale 1ns/1ps
// Kernel engine and transfer channel; hold stalls every completion.
module ncs_engine_model (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Bench control.
    input  wire logic hold,
    // Sequencer side.
    input  wire logic kernel_start,
    input  wire logic xfer_valid,
    output logic      kernel_done,
    output logic      xfer_ready,
    output logic      xfer_done
);
    logic [3:0] kern_q;
    logic [1:0] xact_q;
    logic [2:0] tick_q;
    // Kernel and transfer completions each come only every eighth cycle, so answers are slow.
    assign kernel_done = !hold && tick_q == 3'h0 && kern_q != 4'h0;
    assign xfer_done   = !hold && tick_q == 3'h4 && xact_q != 2'h0;
    assign xfer_ready  = xact_q != 2'h2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kern_q <= 4'h0;
            xact_q <= 2'h0;
            tick_q <= 3'h0;
        end else begin
            kern_q <= kern_q + {3'h0, kernel_start} - {3'h0, kernel_done};
            xact_q <= xact_q + {1'b0, xfer_valid} - {1'b0, xfer_done};
            tick_q <= tick_q + 3'h1;
        end
    end
endmodule

// ---- verif/ncs_sequencer_sva.sv ----
`timescale 1ns/1ps
module ncs_sequencer_sva (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Command stream.
    input wire logic        cmd_valid,
    input wire logic [15:0] short_command_word,
    input wire logic        cmd_ready,
    // Engines.
    input wire logic        kernel_start,
    input wire logic [1:0]  kernel_kind,
    input wire logic [15:0] kernel_mode,
    input wire logic        xfer_valid,
    input wire logic [3:0]  xfer_channel,
    input wire logic        xfer_ready,
    // Host side.
    input wire logic        host_irq,
    input wire logic        stopped
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_take_halt;
        s_take ##0 short_command_word == {ncs_pkg::SHORT_TAG, ncs_pkg::OP_HALT};
    endsequence

    a_take_drop: assert property (s_take |=> !cmd_ready)
        else $error("command ready stayed high after a take");
    a_halt_blocks: assert property (stopped |-> !cmd_ready)
        else $error("command ready while stopped");
    a_halt_irq: assert property ($rose(stopped) |-> host_irq)
        else $error("stop without host interrupt");
    a_halt_hold: assert property (s_take_halt |=> !cmd_ready [*8])
        else $error("command accepted after halt");
    a_xfer_ready: assert property (xfer_valid |-> $past(xfer_ready))
        else $error("descriptor queued while channel full");
    a_xfer_chan: assert property (xfer_valid |-> xfer_channel == ncs_pkg::CHAN_ZERO)
        else $error("descriptor on a channel other than zero");
    a_pool_mode: assert property (kernel_start && kernel_kind == ncs_pkg::KIND_POOL
        |-> kernel_mode <= ncs_pkg::POOL_MODE_MAX)
        else $error("pooling started with illegal mode");
    a_pw_mode: assert property (kernel_start && kernel_kind == ncs_pkg::KIND_POINTWISE
        |-> kernel_mode <= ncs_pkg::PW_MODE_MAX)
        else $error("pointwise started with illegal mode");
    a_conv_mode: assert property (kernel_start && kernel_kind[1] == 1'b0
        |-> kernel_mode == ncs_pkg::CONV_PARAM)
        else $error("convolution started with nonzero parameter");
endmodule

bind ncs_sequencer ncs_sequencer_sva ncs_sequencer_sva_inst (.pclk, .presetn, .cmd_valid,
    .short_command_word, .cmd_ready, .kernel_start, .kernel_kind, .kernel_mode, .xfer_valid,
    .xfer_channel, .xfer_ready, .host_irq, .stopped);

// ---- verif/tb_npu_command_stream_sequencer.sv ----
`timescale 1ns/1ps
module tb_npu_command_stream_sequencer;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        cmd_valid = 1'b0;
    logic [15:0] short_command_word = 16'h0;
    logic [15:0] cmd_param = 16'h0;
    logic        hold = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, cmd_ready, kernel_start, kernel_done;
    logic [1:0]  kernel_kind;
    logic [15:0] kernel_mode;
    logic        xfer_valid, xfer_ready, xfer_done, host_irq, stopped;
    logic [3:0]  xfer_channel;
    logic [31:0] rd;
    logic        re;
    int          err_total = 0;
    int          cmp_count = 0;
    int          kst_n = 0;
    int          xv_n = 0;

    ncs_sequencer ncs_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmd_valid, .short_command_word, .cmd_param, .cmd_ready,
        .kernel_start, .kernel_kind, .kernel_mode, .kernel_done, .xfer_valid, .xfer_channel,
        .xfer_ready, .xfer_done, .host_irq, .stopped);
    ncs_engine_model ncs_engine_model_inst (.pclk, .presetn, .hold, .kernel_start, .xfer_valid,
        .kernel_done, .xfer_ready, .xfer_done);

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        kst_n += (kernel_start === 1'b1);
        xv_n += (xfer_valid === 1'b1);
    end

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic stop_fail();
        err_total++;
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] sw(input logic [9:0] op);
        return {ncs_pkg::SHORT_TAG, op};
    endfunction
    // One APB transfer; the result lands in rd and re.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) stop_fail();
    endtask
    // Offers one command; exp says whether it must be taken.
    task automatic cmd(input logic [15:0] w, input logic [15:0] p, input logic exp);
        int n;
        @(posedge pclk);
        cmd_valid <= 1'b1;
        short_command_word <= w;
        cmd_param <= p;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < (exp ? 300 : 15));
        cmd_valid <= 1'b0;
        if (exp && cmd_ready !== 1'b1) stop_fail();
        else chk({31'h0, cmd_ready}, {31'h0, exp});
    endtask
    // Waits for a new kernel start (what 0) or the host interrupt (what 1).
    task automatic wait_for(input int what, input int n0);
        int n;
        n = 0;
        while (n < 200 && (what == 0 ? kst_n == n0 : host_irq !== 1'b1)) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) stop_fail();
    endtask

    task automatic s_regs();
        apb(1'b0, ncs_pkg::REG_COUNTS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, re}, 32'h1);
    endtask
    task automatic s_kernels();
        int n0;
        logic [9:0] op;
        logic [1:0] kd;
        logic [15:0] md;
        for (int i = 0; i < 11; i++) begin
            op = i == 0 ? ncs_pkg::OP_CONV : i == 1 ? ncs_pkg::OP_PER_CHAN :
                 i < 4 ? ncs_pkg::OP_POOL : ncs_pkg::OP_POINTWISE;
            kd = i < 2 ? 2'(i) : i < 4 ? ncs_pkg::KIND_POOL : ncs_pkg::KIND_POINTWISE;
            md = i < 2 ? 16'h0 : i < 4 ? 16'(i - 2) : 16'(i - 4);
            n0 = kst_n;
            cmd(sw(op), md, 1'b1);
            wait_for(0, n0);
            chk({30'h0, kernel_kind}, {30'h0, kd});
            chk({16'h0, kernel_mode}, {16'h0, md});
        end
    endtask
    task automatic s_invalid();
        int n0;
        n0 = kst_n;
        cmd(sw(10'h004), 16'h0, 1'b1);
        cmd(sw(10'h007), 16'h0, 1'b1);
        cmd(sw(ncs_pkg::OP_POOL), 16'h2, 1'b1);
        cmd({6'h01, ncs_pkg::OP_CONV}, 16'h0, 1'b1);
        repeat (30) @(posedge pclk);
        chk(32'(kst_n - n0), 32'h0);
        cmd(sw(10'h105), 16'h00c3, 1'b1);
        apb(1'b1, ncs_pkg::REG_STATE_IDX, 32'h5);
        apb(1'b0, ncs_pkg::REG_STATE_DATA, 32'h0);
        chk(rd, 32'h0000_00c3);
    endtask
    task automatic s_dep();
        int n0;
        hold <= 1'b1;
        cmd(sw(ncs_pkg::OP_DEP_DIST), 16'h2, 1'b1);
        apb(1'b0, ncs_pkg::REG_COUNTS, 32'h0);
        chk(rd, 32'h0002_0000);
        n0 = kst_n;
        repeat (4) cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        repeat (10) @(posedge pclk);
        chk(32'(kst_n - n0), 32'h3);
        hold <= 1'b0;
        wait_for(0, n0 + 3);
        repeat (60) @(posedge pclk);
        hold <= 1'b1;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        cmd(sw(ncs_pkg::OP_COMPUTE_WAIT), 16'h0, 1'b1);
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b0);
        hold <= 1'b0;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
    endtask
    task automatic s_xfer();
        int n0;
        hold <= 1'b1;
        n0 = xv_n;
        cmd(sw(ncs_pkg::OP_XFER_QUEUE), 16'h0010, 1'b1);
        repeat (2) cmd(sw(ncs_pkg::OP_XFER_QUEUE), 16'h0, 1'b1);
        repeat (5) @(posedge pclk);
        chk(32'(xv_n - n0), 32'h2);
        chk({28'h0, xfer_channel}, 32'h0);
        apb(1'b0, ncs_pkg::REG_COUNTS, 32'h0);
        chk(rd, 32'h0002_0201);
        cmd(sw(ncs_pkg::OP_XFER_WAIT), 16'h1, 1'b1);
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b0);
        hold <= 1'b0;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        repeat (60) @(posedge pclk);
        apb(1'b0, ncs_pkg::REG_COUNTS, 32'h0);
        chk(rd, 32'h0002_0000);
    endtask
    task automatic s_irq();
        hold <= 1'b1;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        cmd(sw(ncs_pkg::OP_HOST_IRQ), 16'ha5a5, 1'b1);
        repeat (10) @(posedge pclk);
        chk({31'h0, host_irq}, 32'h0);
        hold <= 1'b0;
        wait_for(1, 0);
        apb(1'b0, ncs_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'ha5a5_0002);
        apb(1'b1, ncs_pkg::REG_CONTROL, 32'h2);
    endtask
    task automatic s_halt();
        int n0;
        hold <= 1'b1;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        cmd(sw(ncs_pkg::OP_HALT), 16'h1234, 1'b1);
        repeat (10) @(posedge pclk);
        chk({31'h0, host_irq}, 32'h0);
        hold <= 1'b0;
        wait_for(1, 0);
        apb(1'b0, ncs_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h1234_0003);
        chk({31'h0, stopped}, 32'h1);
        n0 = kst_n;
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b0);
        chk(32'(kst_n - n0), 32'h0);
        apb(1'b1, ncs_pkg::REG_CONTROL, 32'h3);
        cmd(sw(ncs_pkg::OP_CONV), 16'h0, 1'b1);
        wait_for(0, n0);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        s_regs();
        s_kernels();
        s_invalid();
        s_dep();
        s_xfer();
        s_irq();
        s_halt();
        report_and_stop();
    end
endmodule
